// [hdl/sysctl_defs.svh]
// ============================================================
// What this block does
// RL1 - latch mode input at reset release
// RL2 - input 1 normal, 0 special single chip
// RL3 - mode bit readable, only special-to-normal writable
// RL4 - normal mode boots through reset vector
// RL5 - special mode activates debug monitor from ROM
// RL6 - stop instruction enters stop unless flash busy
// RL7 - pseudo stop select picks pseudo or full
// RL8 - reset and unmasked pin requests exit stop; other interrupts do not
// RL9 - flash busy delays stop; interrupt cancels it
// RL10 - full stop halts oscillator; periodic/converter may wake
// RL11 - fast wakeup resumes on pll clock
// RL12 - pseudo stop keeps oscillator and few peripherals
// RL13 - wait stops cpu clock; interrupts end it
// RL14 - timer, pwm, converter freeze under debug monitor
// RL15 - por, lvr, pin, illegal address share vector
// RL16 - clock monitor reset own vector, enables
// RL17 - watchdog reset own vector, rate enabled
// RL18 - vectors by priority under relocatable base
// RL19 - traps top two, pin request X-masked next
// RL20 - eight timer channels descending, I-masked, enabled
// RL21 - overflow, accumulator vectors below, wait wake only
// RL22 - clock loss self-clocks or resets
// RL23 - request only when enabled and unmasked
`ifndef SYSCTL_DEFS_SVH
`define SYSCTL_DEFS_SVH
// ============================================================
// register byte offsets
`define OFF_MODE 8'h00
`define OFF_CLOCK_SELECT_REG 8'h04
`define OFF_PLL_CONTROL_REG 8'h08
`define OFF_COPCTL 8'h0C
`define OFF_VBASE 8'h10
`define OFF_IRQEN 8'h14
`define OFF_STATUS 8'h18
// ============================================================
// clock select bits
`define CLK_PSEUDO_STOP_SELECT 0
`define CLK_FAST 1
`define CLK_APIW 2
`define CLK_ATDW 3
`define CLK_FRZT 4
`define CLK_FRZP 5
`define CLK_FRZA 6
// pll control bits
`define PLL_CME 0
`define PLL_SELF_CLOCK_MODE_ENABLE 1
// irq enable bits
`define EN_NONMASKABLE_PIN_REQUEST 0
`define EN_IRQ 1
`define EN_RTI 2
`define EN_CH0 3
`define EN_TOF 11
`define EN_PAOV 12
`define EN_PAI 13
// ============================================================
// reset values
`define RST_CLOCK_SELECT_REG 7'h00
`define RST_PLL_CONTROL_REG 2'h3
`define RST_COP 3'h0
`define RST_VBASE 8'hFF
`define RST_IRQEN 14'h0000
// ============================================================
// vectors
`define VEC_RESET 16'hFFFE
`define VEC_CLKMON 16'hFFFC
`define VEC_COP 16'hFFFA
`define OFS_TRAP 8'hF8
`define OFS_SWI 8'hF6
`define OFS_NONMASKABLE_PIN_REQUEST 8'hF4
`define OFS_IRQ 8'hF2
`define OFS_RTI 8'hF0
`define OFS_CH0 8'hEE
`define OFS_TOF 8'hDE
`define OFS_PAOV 8'hDC
`define OFS_PAI 8'hDA
`endif

// [hdl/sysctl_pkg.sv]
package sysctl_pkg;
  // ============================================================
  // power states
  typedef enum logic [2:0] {
    PS_RUN = 3'b000,
    PS_HOLD = 3'b001,
    PS_FULL = 3'b010,
    PS_PSEUDO = 3'b011,
    PS_WAIT = 3'b100
  } pstate_t;

  typedef struct packed {
    logic capture;
    logic mode;
    logic [6:0] clock_select_reg;
    logic [1:0] pll_control_reg;
    logic [2:0] cop_rate;
    logic [7:0] vbase;
    logic [13:0] irq_en;
    pstate_t pstate;
    logic ack;
    logic [31:0] rdata;
    logic self_clk;
    logic fast_wake;
    logic rst_req;
    logic [15:0] rst_vec;
    logic irq_req;
    logic [15:0] irq_vec;
    logic cpu_en;
    logic sys_en;
    logic osc_en;
    logic keep_en;
    logic dbg;
  } ctl_state_t;
endpackage

// [hdl/chip_mode_power_vector_control.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sysctl_defs.svh"
module chip_mode_power_vector_control (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // mode strap
  input wire logic mode_select_input_i,
  // core events and mask bits
  input wire logic stop_exec_i,
  input wire logic wait_exec_i,
  input wire logic nvm_busy_i,
  input wire logic x_mask_i,
  input wire logic i_mask_i,
  input wire logic trap_unimpl_i,
  input wire logic trap_swi_i,
  // interrupt sources
  input wire logic nonmaskable_pin_request_pin_n_i,
  input wire logic irq_pin_n_i,
  input wire logic rti_req_i,
  input wire logic [7:0] timer_unit_zero_ch_req_i,
  input wire logic timer_unit_zero_ovf_req_i,
  input wire logic timer_unit_zero_paov_req_i,
  input wire logic timer_unit_zero_pai_req_i,
  input wire logic api_wake_i,
  input wire logic atd_wake_i,
  // reset sources
  input wire logic por_i,
  input wire logic lvr_i,
  input wire logic illegal_addr_i,
  input wire logic osc_lost_i,
  input wire logic cop_timeout_i,
  // power and clock control
  output logic cpu_clk_en_o,
  output logic sys_clk_en_o,
  output logic osc_en_o,
  output logic keep_periph_o,
  output logic pll_fast_wake_o,
  output logic self_clock_o,
  output sysctl_pkg::pstate_t power_state_o,
  // mode outputs
  output logic normal_mode_o,
  output logic debug_active_o,
  output logic freeze_tim_o,
  output logic freeze_pwm_o,
  output logic freeze_atd_o,
  // reset and interrupt to core
  output logic reset_req_o,
  output logic [15:0] reset_vector_o,
  output logic irq_req_o,
  output logic [15:0] irq_vector_o
);
  import sysctl_pkg::*;

  ctl_state_t st_r;
  ctl_state_t st_nxt;

  // ============================================================
  // helpers
  function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // fixed priority; lowest bit number wins
  function automatic logic [7:0] vec_ofs(input logic [12:0] pend);
    logic [7:0] ofs;
    ofs = `OFS_PAI;
    for (int i = 12; i >= 0; i--) begin
      if (pend[i]) begin
        ofs = (i == 0) ? `OFS_NONMASKABLE_PIN_REQUEST : (i == 1) ? `OFS_IRQ : (i == 2) ? `OFS_RTI :
              (i <= 10) ? 8'(`OFS_CH0 - 8'(2 * (i - 3))) : (i == 11) ? `OFS_TOF : `OFS_PAOV;
      end
    end
    return ofs;
  endfunction

  // ============================================================
  // request decode
  logic nonmaskable_pin_request_pend;
  logic irq_pend;
  logic [12:0] pend;
  logic any_pend;
  logic stop_wake;
  logic bus_go;
  logic [31:0] wr_val;

  always_comb begin
    nonmaskable_pin_request_pend = ~nonmaskable_pin_request_pin_n_i & st_r.irq_en[`EN_NONMASKABLE_PIN_REQUEST] & ~x_mask_i; // [RL19]
    irq_pend = ~irq_pin_n_i & st_r.irq_en[`EN_IRQ] & ~i_mask_i; // [RL23]
    pend[0] = nonmaskable_pin_request_pend;
    pend[1] = irq_pend;
    pend[2] = rti_req_i & st_r.irq_en[`EN_RTI] & ~i_mask_i;
    pend[10:3] = timer_unit_zero_ch_req_i & st_r.irq_en[`EN_CH0 +: 8] & {8{~i_mask_i}}; // [RL20]
    pend[11] = timer_unit_zero_ovf_req_i & st_r.irq_en[`EN_TOF] & ~i_mask_i; // [RL21]
    pend[12] = timer_unit_zero_paov_req_i & st_r.irq_en[`EN_PAOV] & ~i_mask_i;
    any_pend = (|pend) | (timer_unit_zero_pai_req_i & st_r.irq_en[`EN_PAI] & ~i_mask_i);
    // timer sources are absent here: they wake wait only
    stop_wake = nonmaskable_pin_request_pend | irq_pend | (api_wake_i & st_r.clock_select_reg[`CLK_APIW])
              | (atd_wake_i & st_r.clock_select_reg[`CLK_ATDW]); // [RL8] [RL10] [RL21]
    bus_go = wb_cyc_i & wb_stb_i & ~st_r.ack;
    wr_val = 32'h0000_0000;
    unique case (wb_adr_i)
      `OFF_MODE: wr_val = merge_sel({31'h0000_0000, st_r.mode}, wb_dat_i, wb_sel_i);
      `OFF_CLOCK_SELECT_REG: wr_val = merge_sel({25'h000_0000, st_r.clock_select_reg}, wb_dat_i, wb_sel_i);
      `OFF_PLL_CONTROL_REG: wr_val = merge_sel({30'h0000_0000, st_r.pll_control_reg}, wb_dat_i, wb_sel_i);
      `OFF_COPCTL: wr_val = merge_sel({29'h0000_0000, st_r.cop_rate}, wb_dat_i, wb_sel_i);
      `OFF_VBASE: wr_val = merge_sel({24'h00_0000, st_r.vbase}, wb_dat_i, wb_sel_i);
      `OFF_IRQEN: wr_val = merge_sel({18'h0_0000, st_r.irq_en}, wb_dat_i, wb_sel_i);
      default: wr_val = 32'h0000_0000;
    endcase
  end

  // ============================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.capture = 1'b0;
    st_nxt.rst_req = 1'b0;
    st_nxt.ack = bus_go;
    // strap caught on the first edge after reset release
    if (st_r.capture) begin
      st_nxt.mode = mode_select_input_i; // [RL1] [RL2]
    end
    // register writes
    if (bus_go && wb_we_i) begin
      unique case (wb_adr_i)
        `OFF_MODE: begin
          // one way only: special may step to normal, never back
          if (!st_r.mode && wr_val[0]) begin
            st_nxt.mode = 1'b1; // [RL3]
          end
        end
        `OFF_CLOCK_SELECT_REG: st_nxt.clock_select_reg = wr_val[6:0];
        `OFF_PLL_CONTROL_REG: st_nxt.pll_control_reg = wr_val[1:0];
        `OFF_COPCTL: st_nxt.cop_rate = wr_val[2:0];
        `OFF_VBASE: st_nxt.vbase = wr_val[7:0]; // [RL18]
        `OFF_IRQEN: st_nxt.irq_en = wr_val[13:0];
        default: st_nxt.ack = bus_go;
      endcase
    end
    // register reads; unmapped reads zero
    st_nxt.rdata = 32'h0000_0000;
    if (bus_go && !wb_we_i) begin
      unique case (wb_adr_i)
        `OFF_MODE: st_nxt.rdata = {31'h0000_0000, st_r.mode}; // [RL3]
        `OFF_CLOCK_SELECT_REG: st_nxt.rdata = {25'h000_0000, st_r.clock_select_reg};
        `OFF_PLL_CONTROL_REG: st_nxt.rdata = {30'h0000_0000, st_r.pll_control_reg};
        `OFF_COPCTL: st_nxt.rdata = {29'h0000_0000, st_r.cop_rate};
        `OFF_VBASE: st_nxt.rdata = {24'h00_0000, st_r.vbase};
        `OFF_IRQEN: st_nxt.rdata = {18'h0_0000, st_r.irq_en};
        `OFF_STATUS: st_nxt.rdata = {26'h000_0000, st_r.fast_wake, st_r.self_clk, st_r.dbg, st_r.pstate};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // ============================================================
    // reset sources
    if (por_i || lvr_i || illegal_addr_i) begin
      st_nxt.rst_req = 1'b1;
      st_nxt.rst_vec = `VEC_RESET; // [RL15]
    end else if (osc_lost_i && st_r.pll_control_reg[`PLL_CME] && !st_r.pll_control_reg[`PLL_SELF_CLOCK_MODE_ENABLE]) begin
      st_nxt.rst_req = 1'b1;
      st_nxt.rst_vec = `VEC_CLKMON; // [RL16] [RL22]
    end else if (cop_timeout_i && st_r.cop_rate != 3'h0) begin
      st_nxt.rst_req = 1'b1;
      st_nxt.rst_vec = `VEC_COP; // [RL17]
    end
    if (osc_lost_i && st_r.pll_control_reg[`PLL_CME] && st_r.pll_control_reg[`PLL_SELF_CLOCK_MODE_ENABLE]) begin
      st_nxt.self_clk = 1'b1; // [RL22]
    end
    // ============================================================
    // interrupt vector
    st_nxt.irq_req = 1'b0;
    st_nxt.irq_vec = {st_r.vbase, 8'h00};
    if (trap_unimpl_i) begin
      st_nxt.irq_req = 1'b1;
      st_nxt.irq_vec = {st_r.vbase, `OFS_TRAP}; // [RL19]
    end else if (trap_swi_i) begin
      st_nxt.irq_req = 1'b1;
      st_nxt.irq_vec = {st_r.vbase, `OFS_SWI}; // [RL19]
    end else if (any_pend) begin
      st_nxt.irq_req = 1'b1; // [RL23]
      st_nxt.irq_vec = {st_r.vbase, vec_ofs(pend)}; // [RL18] [RL20] [RL21]
    end
    // ============================================================
    // power state machine
    unique case (st_r.pstate)
      PS_RUN: begin
        if (stop_exec_i) begin
          if (nvm_busy_i) begin
            st_nxt.pstate = PS_HOLD; // [RL9]
          end else begin
            st_nxt.pstate = st_r.clock_select_reg[`CLK_PSEUDO_STOP_SELECT] ? PS_PSEUDO : PS_FULL; // [RL6] [RL7]
            st_nxt.fast_wake = 1'b0;
          end
        end else if (wait_exec_i) begin
          st_nxt.pstate = PS_WAIT; // [RL13]
        end
      end
      PS_HOLD: begin
        // clocks keep running until the flash command completes
        if (any_pend) begin
          st_nxt.pstate = PS_RUN; // [RL9]
        end else if (!nvm_busy_i) begin
          st_nxt.pstate = st_r.clock_select_reg[`CLK_PSEUDO_STOP_SELECT] ? PS_PSEUDO : PS_FULL; // [RL7]
          st_nxt.fast_wake = 1'b0;
        end
      end
      PS_FULL: begin
        if (stop_wake) begin
          st_nxt.pstate = PS_RUN; // [RL8]
          st_nxt.fast_wake = st_r.clock_select_reg[`CLK_FAST]; // [RL11]
        end
      end
      PS_PSEUDO: begin
        if (stop_wake) begin
          st_nxt.pstate = PS_RUN; // [RL8]
        end
      end
      PS_WAIT: begin
        if (any_pend || nonmaskable_pin_request_pend) begin
          st_nxt.pstate = PS_RUN; // [RL13]
        end
      end
      default: st_nxt.pstate = PS_RUN;
    endcase
    // any reset request leaves every low-power state
    if (st_nxt.rst_req) begin
      st_nxt.pstate = PS_RUN; // [RL8]
    end
    st_nxt.cpu_en = (st_nxt.pstate == PS_RUN) || (st_nxt.pstate == PS_HOLD); // [RL13]
    st_nxt.sys_en = st_nxt.cpu_en || (st_nxt.pstate == PS_WAIT); // [RL10] [RL12]
    // fast wake runs on the pll while the oscillator is still off
    st_nxt.osc_en = (st_nxt.pstate != PS_FULL) && !(st_nxt.fast_wake && st_r.pstate == PS_FULL); // [RL10] [RL11]
    st_nxt.keep_en = (st_nxt.pstate == PS_PSEUDO); // [RL12]
    st_nxt.dbg = ~st_nxt.mode; // [RL5]
  end

  // ============================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.capture <= 1'b1;
      st_r.mode <= 1'b1;
      st_r.clock_select_reg <= `RST_CLOCK_SELECT_REG;
      st_r.pll_control_reg <= `RST_PLL_CONTROL_REG;
      st_r.cop_rate <= `RST_COP;
      st_r.vbase <= `RST_VBASE;
      st_r.irq_en <= `RST_IRQEN;
      st_r.pstate <= PS_RUN;
      st_r.rst_vec <= `VEC_RESET; // [RL4] [RL15]
      st_r.irq_vec <= 16'hFF00;
      st_r.cpu_en <= 1'b1;
      st_r.sys_en <= 1'b1;
      st_r.osc_en <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ============================================================
  // outputs
  assign wb_dat_o = st_r.rdata;
  assign wb_ack_o = st_r.ack;
  assign cpu_clk_en_o = st_r.cpu_en;
  assign sys_clk_en_o = st_r.sys_en;
  assign osc_en_o = st_r.osc_en;
  assign keep_periph_o = st_r.keep_en;
  assign pll_fast_wake_o = st_r.fast_wake;
  assign self_clock_o = st_r.self_clk;
  assign power_state_o = st_r.pstate;
  assign normal_mode_o = st_r.mode; // [RL4]
  assign debug_active_o = st_r.dbg; // [RL5]
  assign freeze_tim_o = st_r.clock_select_reg[`CLK_FRZT] & st_r.dbg; // [RL14]
  assign freeze_pwm_o = st_r.clock_select_reg[`CLK_FRZP] & st_r.dbg; // [RL14]
  assign freeze_atd_o = st_r.clock_select_reg[`CLK_FRZA] & st_r.dbg; // [RL14]
  assign reset_req_o = st_r.rst_req;
  assign reset_vector_o = st_r.rst_vec;
  assign irq_req_o = st_r.irq_req;
  assign irq_vector_o = st_r.irq_vec;

  // ============================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence stop_busy_s;
    st_r.pstate == PS_RUN && stop_exec_i && nvm_busy_i && !st_nxt.rst_req;
  endsequence
  sequence cancel_s;
    st_r.pstate == PS_HOLD && any_pend && !st_nxt.rst_req;
  endsequence

  mode_latch_a: assert property ($fell(rst_i) |=> st_r.mode == $past(mode_select_input_i)) // [RL1]
    else $error("mode not latched");
  mode_one_way_a: assert property (st_r.mode && !st_r.capture |=> st_r.mode) // [RL3]
    else $error("mode returned to special");
  stop_defer_a: assert property (stop_busy_s |=> st_r.pstate == PS_HOLD && cpu_clk_en_o) // [RL9]
    else $error("stop not deferred");
  stop_cancel_a: assert property (cancel_s |=> st_r.pstate == PS_RUN) // [RL9]
    else $error("stop not cancelled");
  pseudo_stop_select_pick_a: assert property (st_r.pstate == PS_RUN && stop_exec_i && !nvm_busy_i && !st_nxt.rst_req
    |=> st_r.pstate == ($past(st_r.clock_select_reg[`CLK_PSEUDO_STOP_SELECT]) ? PS_PSEUDO : PS_FULL)) // [RL6] [RL7]
    else $error("wrong stop kind");
  full_osc_a: assert property (st_r.pstate == PS_FULL |-> !osc_en_o && !sys_clk_en_o) // [RL10]
    else $error("clocks alive in full stop");
  pseudo_osc_a: assert property (st_r.pstate == PS_PSEUDO |-> osc_en_o && !sys_clk_en_o && keep_periph_o) // [RL12]
    else $error("pseudo stop clocks wrong");
  wake_stop_a: assert property ((st_r.pstate == PS_FULL || st_r.pstate == PS_PSEUDO) && nonmaskable_pin_request_pend
    |=> st_r.pstate == PS_RUN ##0 cpu_clk_en_o) // [RL8]
    else $error("no wake on pin request");
  wait_gate_a: assert property (st_r.pstate == PS_WAIT |-> !cpu_clk_en_o && sys_clk_en_o) // [RL13]
    else $error("wait clocks wrong");
  cop_vec_a: assert property (cop_timeout_i && st_r.cop_rate != 3'h0 && !por_i && !lvr_i && !illegal_addr_i && !osc_lost_i
    |=> reset_req_o && reset_vector_o == `VEC_COP) // [RL17]
    else $error("watchdog vector wrong");
  masked_a: assert property (i_mask_i && x_mask_i && !trap_unimpl_i && !trap_swi_i |=> !irq_req_o) // [RL23]
    else $error("masked request presented");
  ch_vec_a: assert property (timer_unit_zero_ch_req_i[7] && st_r.irq_en[`EN_CH0 + 7] && !i_mask_i && pend[6:0] == 7'h00
    && timer_unit_zero_ch_req_i[6:0] == 7'h00 && !trap_unimpl_i && !trap_swi_i
    |=> irq_vector_o == {$past(st_r.vbase), 8'hE0}) // [RL20]
    else $error("channel vector wrong");
endmodule // chip_mode_power_vector_control
`default_nettype wire

// [dv/core_model.sv]
`timescale 1ns/1ns
`default_nettype none
module core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bench requests
  input wire logic stop_cmd_i,
  input wire logic wait_cmd_i,
  input wire logic strap_i,
  // design side
  input wire sysctl_pkg::pstate_t power_state_i,
  output logic stop_exec_o,
  output logic wait_exec_o,
  output logic mode_select_o
);
  import sysctl_pkg::*;
  // ============================================================
  // instruction issue
  // a halted core fetches nothing, so stop and wait issue only from run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_exec_o <= 1'b0;
      wait_exec_o <= 1'b0;
    end else begin
      stop_exec_o <= stop_cmd_i && (power_state_i == PS_RUN);
      wait_exec_o <= wait_cmd_i && (power_state_i == PS_RUN);
    end
  end
  // strap level held steady across reset release
  assign mode_select_o = strap_i;
endmodule // core_model
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sysctl_defs.svh"
module tb;
  import sysctl_pkg::*;
  // ============================================================
  // signals
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, strap = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  logic ack, scmd = 1'b0, wcmd = 1'b0, sx, wx, msel, nvm = 1'b0, xm = 1'b1, im = 1'b1, tu = 1'b0, ts = 1'b0;
  logic [13:0] src = 14'h0000;
  logic [4:0] rs = 5'h00;
  logic autonomous_periodic_wakeup = 1'b0, analog_converter_unit = 1'b0, cpu, sys, osc, keep, fastw, selfc, nmode, dbg, fzt, fzp, fza, rreq, ireq;
  logic [15:0] rvec, ivec;
  pstate_t pst;
  int n_mismatch = 0, tests_run = 0, cycles = 0, k;
  logic [31:0] q;
  logic seen;
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  core_model u_core_model (.clk_i(clk_i), .rst_i(rst_i), .stop_cmd_i(scmd), .wait_cmd_i(wcmd), .strap_i(strap),
    .power_state_i(pst), .stop_exec_o(sx), .wait_exec_o(wx), .mode_select_o(msel));
  chip_mode_power_vector_control u_chip_mode_power_vector_control (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .mode_select_input_i(msel), .stop_exec_i(sx), .wait_exec_i(wx),
    .nvm_busy_i(nvm), .x_mask_i(xm), .i_mask_i(im), .trap_unimpl_i(tu), .trap_swi_i(ts),
    .nonmaskable_pin_request_pin_n_i(~src[0]), .irq_pin_n_i(~src[1]), .rti_req_i(src[2]), .timer_unit_zero_ch_req_i(src[10:3]),
    .timer_unit_zero_ovf_req_i(src[11]), .timer_unit_zero_paov_req_i(src[12]), .timer_unit_zero_pai_req_i(src[13]), .api_wake_i(autonomous_periodic_wakeup),
    .atd_wake_i(analog_converter_unit), .por_i(rs[0]), .lvr_i(rs[1]), .illegal_addr_i(rs[2]), .osc_lost_i(rs[3]),
    .cop_timeout_i(rs[4]), .cpu_clk_en_o(cpu), .sys_clk_en_o(sys), .osc_en_o(osc), .keep_periph_o(keep),
    .pll_fast_wake_o(fastw), .self_clock_o(selfc), .power_state_o(pst), .normal_mode_o(nmode),
    .debug_active_o(dbg), .freeze_tim_o(fzt), .freeze_pwm_o(fzp), .freeze_atd_o(fza), .reset_req_o(rreq),
    .reset_vector_o(rvec), .irq_req_o(ireq), .irq_vector_o(ivec));
  // ============================================================
  // tasks
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // classic single cycle; ack is sampled at the edge, so read data is taken there too
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk({31'h0, ack}, 32'h0000_0001, "bus ack");
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, e, "read data");
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk_i);
    rst_i <= 1'b1;
    strap <= s;
    tick(2);
    rst_i <= 1'b0;
    tick(2);
  endtask
  task automatic cmd(input logic is_stop);
    @(posedge clk_i);
    scmd <= is_stop;
    wcmd <= ~is_stop;
    @(posedge clk_i);
    scmd <= 1'b0;
    wcmd <= 1'b0;
    tick(3);
  endtask
  task automatic set_src(input logic [13:0] v);
    @(posedge clk_i);
    src <= v;
    tick(3);
  endtask
  task automatic pulse_rst(input int b, input logic [15:0] e);
    @(posedge clk_i);
    rs <= 5'(1 << b);
    @(posedge clk_i);
    rs <= 5'h00;
    seen = 1'b0;
    repeat (4) begin
      @(posedge clk_i);
      seen = seen | (rreq === 1'b1);
    end
    chk({31'h0, seen}, 32'h0000_0001, "reset request");
    chk({16'h0, rvec}, {16'h0, e}, "reset vector");
  endtask
  // ============================================================
  // timeout: the full sequence needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      close_out();
    end
  end
  // ============================================================
  // sequence
  initial begin
    do_reset(1'b1);
    chk({31'h0, nmode}, 32'h0000_0001, "normal mode");
    chk({31'h0, dbg}, 32'h0000_0000, "debug off");
    rd(`OFF_CLOCK_SELECT_REG, 32'h0000_0000);
    rd(`OFF_PLL_CONTROL_REG, 32'h0000_0003);
    rd(`OFF_VBASE, 32'h0000_00ff);
    rd(`OFF_IRQEN, 32'h0000_0000);
    xfer(1'b1, 8'h1c, 32'hffff_ffff);
    rd(8'h1c, 32'h0000_0000);
    do_reset(1'b0);
    chk({31'h0, nmode}, 32'h0000_0000, "special mode");
    chk({31'h0, dbg}, 32'h0000_0001, "debug on");
    xfer(1'b1, `OFF_CLOCK_SELECT_REG, 32'h0000_0070);
    tick(2);
    chk({29'h0, fzt, fzp, fza}, 32'h0000_0007, "freeze on");
    xfer(1'b1, `OFF_MODE, 32'h0000_0001);
    rd(`OFF_MODE, 32'h0000_0001);
    xfer(1'b1, `OFF_MODE, 32'h0000_0000);
    rd(`OFF_MODE, 32'h0000_0001);
    chk({29'h0, fzt, fzp, fza}, 32'h0000_0000, "freeze off");
    // vector order: each source against the lowest one, under a moved base
    xfer(1'b1, `OFF_VBASE, 32'h0000_0012);
    xfer(1'b1, `OFF_IRQEN, 32'h0000_3fff);
    @(posedge clk_i);
    im <= 1'b0;
    xm <= 1'b0;
    for (k = 0; k < 14; k++) begin
      set_src(14'(1 << k) | 14'h2000);
      chk({31'h0, ireq}, 32'h0000_0001, "irq raised");
      chk({16'h0, ivec}, {16'h0012, 8'hf4 - 8'(2 * k)}, "irq vector");
    end
    @(posedge clk_i);
    im <= 1'b1;
    xm <= 1'b1;
    set_src(14'h0005);
    chk({31'h0, ireq}, 32'h0000_0000, "masked");
    @(posedge clk_i);
    tu <= 1'b1;
    ts <= 1'b1;
    tick(3);
    chk({16'h0, ivec}, 32'h0000_12f8, "trap vector");
    @(posedge clk_i);
    tu <= 1'b0;
    tick(3);
    chk({16'h0, ivec}, 32'h0000_12f6, "swi vector");
    @(posedge clk_i);
    ts <= 1'b0;
    im <= 1'b0;
    xm <= 1'b0;
    // pin request stays asserted, so its enable goes off together with the tick's
    xfer(1'b1, `OFF_IRQEN, 32'h0000_3ffa);
    tick(3);
    chk({31'h0, ireq}, 32'h0000_0000, "rti disabled");
    // stop entry and exit
    set_src(14'h0000);
    xfer(1'b1, `OFF_IRQEN, 32'h0000_0009);
    xfer(1'b1, `OFF_CLOCK_SELECT_REG, 32'h0000_0001);
    cmd(1'b1);
    chk({29'h0, pst}, {29'h0, PS_PSEUDO}, "pseudo stop");
    chk({28'h0, cpu, sys, osc, keep}, 32'h0000_0003, "pseudo clocks");
    set_src(14'h0008);
    chk({29'h0, pst}, {29'h0, PS_PSEUDO}, "timer no wake");
    set_src(14'h0001);
    chk({29'h0, pst}, {29'h0, PS_RUN}, "pin wake");
    set_src(14'h0000);
    xfer(1'b1, `OFF_CLOCK_SELECT_REG, 32'h0000_0006);
    cmd(1'b1);
    chk({29'h0, pst}, {29'h0, PS_FULL}, "full stop");
    chk({31'h0, osc}, 32'h0000_0000, "osc off");
    @(posedge clk_i);
    autonomous_periodic_wakeup <= 1'b1;
    seen = 1'b0;
    repeat (4) begin
      @(posedge clk_i);
      seen = seen | (fastw === 1'b1);
    end
    chk({31'h0, seen}, 32'h0000_0001, "fast wake");
    chk({29'h0, pst}, {29'h0, PS_RUN}, "api wake");
    autonomous_periodic_wakeup <= 1'b0;
    // stop held by a flash command, cancelled, then completed
    xfer(1'b1, `OFF_CLOCK_SELECT_REG, 32'h0000_0001);
    nvm <= 1'b1;
    cmd(1'b1);
    chk({29'h0, pst}, {29'h0, PS_HOLD}, "stop held");
    chk({31'h0, sys}, 32'h0000_0001, "clocks run");
    set_src(14'h0001);
    chk({29'h0, pst}, {29'h0, PS_RUN}, "stop cancel");
    set_src(14'h0000);
    cmd(1'b1);
    nvm <= 1'b0;
    tick(3);
    chk({29'h0, pst}, {29'h0, PS_PSEUDO}, "late stop");
    set_src(14'h0001);
    set_src(14'h0000);
    // wait mode
    xfer(1'b1, `OFF_IRQEN, 32'h0000_0004);
    cmd(1'b0);
    chk({29'h0, pst}, {29'h0, PS_WAIT}, "wait");
    chk({30'h0, cpu, sys}, 32'h0000_0001, "wait clocks");
    set_src(14'h0004);
    chk({29'h0, pst}, {29'h0, PS_RUN}, "wait wake");
    set_src(14'h0000);
    // reset sources
    xfer(1'b1, `OFF_COPCTL, 32'h0000_0001);
    xfer(1'b1, `OFF_PLL_CONTROL_REG, 32'h0000_0001);
    pulse_rst(3, `VEC_CLKMON);
    pulse_rst(4, `VEC_COP);
    for (k = 0; k < 3; k++) begin
      pulse_rst(k, `VEC_RESET);
    end
    xfer(1'b1, `OFF_PLL_CONTROL_REG, 32'h0000_0003);
    @(posedge clk_i);
    rs <= 5'h08;
    tick(3);
    chk({31'h0, selfc}, 32'h0000_0001, "self clock");
    rd(`OFF_STATUS, 32'h0000_0010);
    close_out();
  end
endmodule // tb
`default_nettype wire
